// >>> src/siu_core.sv
// System integration unit: reset sequencing, reset causes, stop recovery and
// interrupt arbitration with stacking control for the CPU core.
// Assumes clk_sys_in is the crystal clock and all inputs except rstn_in are synchronous to it.
//
// Local design decisions: strobed register access and the address map.

// Notes on behaviour
// - Power-on: pin low 4096+32, then 32+3 more
// - Recovery 4163 for power/low-voltage, 67 for other internal sources
// - Power-on holds CPU clocks off, generator on
// - Power-on sets its flag, clears others
// - Watchdog overflow resets, flags, pulls pin low
// - Watchdog disabled only by high-voltage pin conditions
// - Illegal instruction flags and resets
// - Stop with stop disabled is illegal opcode
// - Only opcode fetch from unmapped address resets
// - Low voltage flags, long pin low, release
// - Monitor entry reset causes internal reset
// - Twelve-bit counter also prescales the watchdog
// - Stop clears counter; recovery 32 or 4096
// - Pin reset leaves counter; counter free-runs
// - Entry stacks registers, sets mask; return restores
// - Latched interrupt cannot be preempted
// - Hardware interrupt only at instruction end, unmasked
// - Fixed priority from reset down to timebase
// - High index register is never stacked
// - Software interrupt ignores mask, pushes PC
// - Sixteen read-only pending flags by priority
// - Internal reset clears counter; all assert reset
// - Pin flag after 67 low cycles, not long
// - Reading cause register clears its flags
module siu_core
    import siu_pkg::*;
(
    input  wire logic         clk_sys_in,       // Crystal clock.
    input  wire logic         rstn_in,          // Async power-on reset, active low.
    input  wire siu_bus_req_t bus_req_in,       // Register port request.
    output logic [7:0]        bus_rdata_out,    // Read data, one cycle after read.
    input  wire logic         power_on_pulse_in,// Power-on pulse.
    input  wire logic         lvi_in,           // Low-voltage detector output.
    input  wire logic         wdog_ovf_in,      // Watchdog counter overflow.
    input  wire logic         mon_reset_in,     // Monitor entry reset request.
    input  wire logic         monitor_mode_in,  // Device is in monitor mode.
    input  wire logic         break_in,         // Break state request.
    input  wire logic         rst_hv_in,        // Reset pin at high test voltage.
    input  wire logic         irq_hv_in,        // Interrupt pin at high test voltage.
    input  wire logic         rst_pin_in,       // Reset pin level.
    output logic              rst_pin_out,      // Reset pin drive value.
    output logic              rst_pin_oe_out,   // Reset pin output enable.
    input  wire siu_cpu_t     cpu_in,           // Decoded CPU status.
    input  wire logic [15:0]  irq_req_in,       // Requests, bit 0 is flag 1.
    input  wire logic [15:0]  irq_en_in,        // Source enables, bit 0 is flag 1.
    output siu_stack_t        stack_out,        // Stacking control to the CPU.
    output logic              internal_reset_out,// Internal reset, active high.
    output logic              clk_gen_en_out,   // Clock generator output enable.
    output logic              cpu_clk_en_out,   // CPU and module clock enable.
    output logic              wdog_disable_out, // Watchdog disable.
    output logic [11:0]       cnt_out           // Counter, watchdog prescaler.
);

    typedef struct packed {
        siu_rst_st_t rst_st;
        logic [11:0] cnt;
        logic [6:0]  ext_cnt;
        logic        ext_rel;
        logic        long_seq;
        logic [7:0]  cause;
        logic [7:0]  cfg;
        logic [15:0] ifl;
        logic [7:0]  rd_data;
        logic        wdog_dis;
        logic        internal_reset;
        logic        pin_oe;
        logic        cgen;
        logic        cpu_clk;
        siu_xs_t     xs;
        logic [2:0]  step;
        logic        latched;
        siu_stack_t  stk;
    } siu_state_t;

    localparam siu_state_t SIU_STATE_RST = '{
        rst_st:   ST_LONG,
        cnt:      12'h000,
        ext_cnt:  7'h00,
        ext_rel:  1'b0,
        long_seq: 1'b1,
        cause:    SIU_CAUSE_RST,
        cfg:      SIU_CFG_RST,
        ifl:      16'h0000,
        rd_data:  8'h00,
        wdog_dis: 1'b0,
        internal_reset:     1'b1,
        pin_oe:   1'b1,
        cgen:     1'b1,
        cpu_clk:  1'b0,
        xs:       XS_IDLE,
        step:     3'h0,
        latched:  1'b0,
        stk:      '0
    };

    siu_state_t s_reg;
    siu_state_t s_next;

    logic        wdog_trig;
    logic        illegal_opcode_cause_trig;
    logic        illegal_address_cause_trig;
    logic        short_trig;
    logic        long_trig;
    logic [7:0]  cause_set;
    logic [15:0] pend;
    logic        hw_hit;
    logic [3:0]  hw_idx;
    logic        wake;

    // Reset sources and the cause bits they set this cycle.
    always_comb
    begin
        wdog_trig  = wdog_ovf_in & ~s_reg.wdog_dis;
        illegal_opcode_cause_trig  = cpu_in.illegal_op
                   | (cpu_in.stop_exec & ~s_reg.cfg[SIU_CFG_STOP_EN]);
        illegal_address_cause_trig  = cpu_in.unmapped & cpu_in.opcode_fetch;
        short_trig = wdog_trig | illegal_opcode_cause_trig | illegal_address_cause_trig | mon_reset_in;
        long_trig  = power_on_pulse_in | lvi_in;
        cause_set  = 8'h00;
        cause_set[SIU_CAUSE_WDOG] = wdog_trig;
        cause_set[SIU_CAUSE_ILLEGAL_OPCODE_CAUSE] = illegal_opcode_cause_trig;
        cause_set[SIU_CAUSE_ILLEGAL_ADDRESS_CAUSE] = illegal_address_cause_trig;
        cause_set[SIU_CAUSE_MON]  = mon_reset_in;
        cause_set[SIU_CAUSE_LVI]  = lvi_in;
        cause_set[SIU_CAUSE_POR]  = power_on_pulse_in;
        cause_set[SIU_CAUSE_PIN]  = (s_reg.rst_st == ST_EXT) & ~s_reg.long_seq
                                  & (s_reg.ext_cnt == SIU_EXT_END);
    end

    // Highest-priority enabled hardware request; flag 1 wins over flag 16.
    always_comb
    begin
        pend   = irq_req_in & irq_en_in;
        hw_hit = 1'b0;
        hw_idx = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (pend[i])
            begin
                hw_hit = 1'b1;
                hw_idx = 4'(i);
            end
        end
        wake = hw_hit | break_in | cpu_in.software_interrupt;
    end

    // Next-state logic for the whole unit.
    always_comb
    begin
        s_next          = s_reg;
        s_next.cnt      = s_reg.cnt + 12'h001;
        s_next.ifl      = irq_req_in;
        s_next.stk.push = 1'b0;
        s_next.stk.pop  = 1'b0;
        s_next.stk.set_mask = 1'b0;
        s_next.wdog_dis = (monitor_mode_in & (rst_hv_in | irq_hv_in))
                        | (break_in & rst_hv_in);

        // Reset sequencer; the counter paces ST_LONG to ST_TAIL and ST_WAKE, while ST_EXT uses ext_cnt.
        unique case (s_reg.rst_st)
            ST_RUN:
            begin
                if (!rst_pin_in)
                begin
                    s_next.rst_st   = ST_EXT;
                    s_next.ext_cnt  = 7'h01;
                    s_next.ext_rel  = 1'b0;
                    s_next.long_seq = 1'b0;
                end
                else if (cpu_in.stop_exec && s_reg.cfg[SIU_CFG_STOP_EN])
                begin
                    s_next.rst_st = ST_STOP;
                    s_next.cnt    = 12'h000;
                end
            end
            ST_LONG:
            begin
                if (s_reg.cnt == SIU_LONG_END)
                begin
                    s_next.rst_st = ST_PIN;
                end
            end
            ST_PIN:
            begin
                if (s_reg.cnt == SIU_PIN_END)
                begin
                    s_next.rst_st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (s_reg.cnt == SIU_HOLD_END)
                begin
                    s_next.rst_st = ST_TAIL;
                end
            end
            ST_TAIL:
            begin
                if (s_reg.cnt == SIU_TAIL_END)
                begin
                    s_next.rst_st = ST_RUN;
                end
            end
            ST_EXT:
            begin
                // Low time is measured without touching the shared counter.
                if (!s_reg.ext_rel)
                begin
                    if (s_reg.ext_cnt != SIU_EXT_END)
                    begin
                        s_next.ext_cnt = s_reg.ext_cnt + 7'h01;
                    end
                    if (rst_pin_in)
                    begin
                        s_next.ext_rel = 1'b1;
                        s_next.ext_cnt = 7'h00;
                    end
                end
                else if (s_reg.ext_cnt == SIU_ETAIL_END)
                begin
                    s_next.rst_st = ST_RUN;
                end
                else
                begin
                    s_next.ext_cnt = s_reg.ext_cnt + 7'h01;
                end
            end
            ST_STOP:
            begin
                s_next.cnt = 12'h000;
                if (!rst_pin_in)
                begin
                    s_next.rst_st   = ST_EXT;
                    s_next.ext_cnt  = 7'h01;
                    s_next.ext_rel  = 1'b0;
                    s_next.long_seq = 1'b0;
                end
                else if (wake)
                begin
                    s_next.rst_st = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if (s_reg.cfg[SIU_CFG_SHORT_STOP_RECOVERY] ? (s_reg.cnt == SIU_PIN_END)
                                             : (s_reg.cnt == SIU_LONG_END))
                begin
                    s_next.rst_st = ST_RUN;
                end
            end
        endcase

        // Internal sources restart the sequence; long and short ones both clear the counter.
        if (long_trig)
        begin
            s_next.rst_st   = ST_LONG;
            s_next.cnt      = 12'h000;
            s_next.long_seq = 1'b1;
        end
        else if (short_trig)
        begin
            s_next.rst_st   = ST_PIN;
            s_next.cnt      = 12'h000;
            s_next.long_seq = 1'b0;
        end

        // Cause flags: a set in the reading cycle survives the clear.
        if (power_on_pulse_in)
        begin
            s_next.cause = SIU_CAUSE_RST;
        end
        else if (bus_req_in.rd && bus_req_in.addr == SIU_ADDR_CAUSE)
        begin
            s_next.cause = cause_set;
        end
        else
        begin
            s_next.cause = s_reg.cause | cause_set;
        end

        // Register port: configuration write and registered read data.
        if (bus_req_in.wr && bus_req_in.addr == SIU_ADDR_CFG)
        begin
            s_next.cfg = bus_req_in.wdata & 8'h03;
        end
        s_next.rd_data = 8'h00;
        if (bus_req_in.rd)
        begin
            unique case (bus_req_in.addr)
                SIU_ADDR_CAUSE: s_next.rd_data = s_reg.cause;
                // Flag 1 sits at bit 2 of the first status register, higher flags above it.
                SIU_ADDR_INT1:  s_next.rd_data = {s_reg.ifl[5:0], 2'b00};
                SIU_ADDR_INT2:  s_next.rd_data = s_reg.ifl[13:6];
                SIU_ADDR_INT3:  s_next.rd_data = {6'h00, s_reg.ifl[15:14]};
                SIU_ADDR_CFG:   s_next.rd_data = s_reg.cfg;
                default:        s_next.rd_data = 8'h00;
            endcase
        end

        // Exception sequencer: latch, push five items, or pop them on return.
        unique case (s_reg.xs)
            XS_IDLE:
            begin
                if (s_reg.rst_st == ST_RUN && cpu_in.instr_end)
                begin
                    if (cpu_in.software_interrupt && !s_reg.latched)
                    begin
                        s_next.xs               = XS_PUSH;
                        s_next.latched          = 1'b1;
                        s_next.stk.vec          = SIU_VEC_SWI;
                        s_next.stk.pc_minus_one = 1'b0;
                        s_next.step             = SIU_ITEM_PCL;
                    end
                    else if (hw_hit && !cpu_in.i_mask && !s_reg.latched)
                    begin
                        s_next.xs               = XS_PUSH;
                        s_next.latched          = 1'b1;
                        s_next.stk.vec          = SIU_VEC_HW0 + 5'(hw_idx);
                        s_next.stk.pc_minus_one = 1'b1;
                        s_next.step             = SIU_ITEM_PCL;
                    end
                    else if (cpu_in.return_from_interrupt)
                    begin
                        s_next.xs   = XS_POP;
                        s_next.step = SIU_ITEM_CCR;
                    end
                end
            end
            XS_PUSH:
            begin
                // Only PC, X, A and CCR are stacked; H stays with software.
                s_next.stk.push = 1'b1;
                s_next.stk.item = s_reg.step;
                s_next.step     = s_reg.step + 3'h1;
                if (s_reg.step == SIU_ITEM_CCR)
                begin
                    s_next.xs            = XS_IDLE;
                    s_next.stk.set_mask  = 1'b1;
                    s_next.stk.vec_valid = 1'b1;
                end
            end
            XS_POP:
            begin
                s_next.stk.pop  = 1'b1;
                s_next.stk.item = s_reg.step;
                s_next.step     = s_reg.step - 3'h1;
                if (s_reg.step == SIU_ITEM_PCL)
                begin
                    s_next.xs            = XS_IDLE;
                    s_next.latched       = 1'b0;
                    s_next.stk.vec_valid = 1'b0;
                end
            end
            default:
            begin
                s_next.xs = XS_IDLE;
            end
        endcase

        // Any reset abandons an exception in progress.
        if (s_next.rst_st != ST_RUN && s_next.rst_st != ST_STOP && s_next.rst_st != ST_WAKE)
        begin
            s_next.xs      = XS_IDLE;
            s_next.latched = 1'b0;
            s_next.stk     = '0;
            s_next.stk.vec = SIU_VEC_RESET;
        end

        // Output flops follow the next sequencer state.
        s_next.internal_reset    = s_next.rst_st inside {ST_LONG, ST_PIN, ST_HOLD, ST_TAIL, ST_EXT};
        s_next.pin_oe  = s_next.rst_st inside {ST_LONG, ST_PIN};
        s_next.cgen    = s_next.rst_st != ST_STOP;
        s_next.cpu_clk = !(s_next.rst_st inside {ST_LONG, ST_STOP, ST_WAKE});
    end

    // Single state register of the unit.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_reg <= SIU_STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs; the reset pin is only ever pulled low.
    assign rst_pin_out        = 1'b0;
    assign rst_pin_oe_out     = s_reg.pin_oe;
    assign internal_reset_out = s_reg.internal_reset;
    assign clk_gen_en_out     = s_reg.cgen;
    assign cpu_clk_en_out     = s_reg.cpu_clk;
    assign wdog_disable_out   = s_reg.wdog_dis;
    assign cnt_out            = s_reg.cnt;
    assign bus_rdata_out      = s_reg.rd_data;
    assign stack_out          = s_reg.stk;

endmodule

// >>> src/siu_pkg.sv
// Shared constants and carrier types for the system integration unit.
// Assumes one crystal clock drives the whole unit and an 8-bit register port.
package siu_pkg;

    // Register addresses on the plain register port.
    localparam logic [15:0] SIU_ADDR_CAUSE = 16'hFE01;
    localparam logic [15:0] SIU_ADDR_INT1  = 16'hFE04;
    localparam logic [15:0] SIU_ADDR_INT2  = 16'hFE05;
    localparam logic [15:0] SIU_ADDR_INT3  = 16'hFE06;
    localparam logic [15:0] SIU_ADDR_CFG   = 16'hFE08;

    // Reset cause register bit positions and value after power-on.
    localparam int unsigned SIU_CAUSE_POR  = 7;
    localparam int unsigned SIU_CAUSE_PIN  = 6;
    localparam int unsigned SIU_CAUSE_WDOG = 5;
    localparam int unsigned SIU_CAUSE_ILLEGAL_OPCODE_CAUSE = 4;
    localparam int unsigned SIU_CAUSE_ILLEGAL_ADDRESS_CAUSE = 3;
    localparam int unsigned SIU_CAUSE_MON  = 2;
    localparam int unsigned SIU_CAUSE_LVI  = 1;
    localparam logic [7:0]  SIU_CAUSE_RST  = 8'h80;

    // Configuration register bits and reset value.
    localparam int unsigned SIU_CFG_STOP_EN = 0;
    localparam int unsigned SIU_CFG_SHORT_STOP_RECOVERY   = 1;
    localparam logic [7:0]  SIU_CFG_RST     = 8'h00;

    // Phase lengths in crystal clock cycles.
    localparam int unsigned SIU_LONG_CYC = 32'h0000_1000;
    localparam int unsigned SIU_PIN_CYC  = 32'h0000_0020;
    localparam int unsigned SIU_HOLD_CYC = 32'h0000_0020;
    localparam int unsigned SIU_TAIL_CYC = 32'h0000_0003;
    localparam int unsigned SIU_EXT_MIN  = 32'h0000_0043;
    localparam int unsigned SIU_REC_LONG = SIU_LONG_CYC + SIU_PIN_CYC + SIU_HOLD_CYC + SIU_TAIL_CYC;
    localparam int unsigned SIU_REC_SHORT = SIU_PIN_CYC + SIU_HOLD_CYC + SIU_TAIL_CYC;

    // Counter values that close each phase.
    localparam logic [11:0] SIU_LONG_END = 12'(SIU_LONG_CYC - 1);
    localparam logic [11:0] SIU_PIN_END  = 12'(SIU_PIN_CYC - 1);
    localparam logic [11:0] SIU_HOLD_END = 12'(SIU_PIN_CYC + SIU_HOLD_CYC - 1);
    localparam logic [11:0] SIU_TAIL_END = 12'(SIU_REC_SHORT - 1);
    localparam logic [6:0]  SIU_EXT_END  = 7'(SIU_EXT_MIN);
    localparam logic [6:0]  SIU_ETAIL_END = 7'(SIU_TAIL_CYC - 1);

    // Vector selector codes; hardware sources follow from code 2 upward.
    localparam logic [4:0] SIU_VEC_RESET = 5'h00;
    localparam logic [4:0] SIU_VEC_SWI   = 5'h01;
    localparam logic [4:0] SIU_VEC_HW0   = 5'h02;

    // Stack items, in push order; pop runs in reverse.
    localparam logic [2:0] SIU_ITEM_PCL = 3'h0;
    localparam logic [2:0] SIU_ITEM_CCR = 3'h4;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_LONG = 3'b001,
        ST_PIN  = 3'b010,
        ST_HOLD = 3'b011,
        ST_TAIL = 3'b100,
        ST_EXT  = 3'b101,
        ST_STOP = 3'b110,
        ST_WAKE = 3'b111
    } siu_rst_st_t;

    typedef enum logic [1:0] {
        XS_IDLE = 2'b00,
        XS_PUSH = 2'b01,
        XS_POP  = 2'b10
    } siu_xs_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } siu_bus_req_t;

    typedef struct packed {
        logic instr_end;
        logic i_mask;
        logic software_interrupt;
        logic return_from_interrupt;
        logic illegal_op;
        logic stop_exec;
        logic opcode_fetch;
        logic unmapped;
    } siu_cpu_t;

    typedef struct packed {
        logic       push;
        logic       pop;
        logic [2:0] item;
        logic       pc_minus_one;
        logic       set_mask;
        logic       vec_valid;
        logic [4:0] vec;
    } siu_stack_t;

endpackage

// >>> test/siu_core_tb.sv
// Self-checking bench for siu_core: reset sources, causes and interrupt entry.
// Assumes the reset pin is resolved by siu_pin_model.
module siu_core_tb
    import siu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys_in = 1'b0, rstn_in = 1'b0, lvi_in = 1'b0, wdog_ovf_in = 1'b0;
    logic         mon_reset_in = 1'b0, ext_low = 1'b0, rst_pin_in, rst_pin_out, rst_pin_oe_out;
    logic         internal_reset_out, clk_gen_en_out, cpu_clk_en_out, wdog_disable_out;
    siu_bus_req_t bus_req_in = '0;
    siu_cpu_t     cpu_in = '0;
    siu_stack_t   stack_out;
    logic [15:0]  irq_req_in = '0, irq_en_in = '0;
    logic [11:0]  cnt_out;
    logic [7:0]   bus_rdata_out;
    int           n_errors = 0, samples_checked = 0;
    siu_core i_dut (.*, .power_on_pulse_in(1'b0), .monitor_mode_in(1'b0), .break_in(1'b0),
        .rst_hv_in(1'b0), .irq_hv_in(1'b0));
    siu_pin_model i_pin (.oe_in(rst_pin_oe_out), .low_in(ext_low), .pin_out(rst_pin_in));
    // Crystal clock at 100 MHz.
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One register cycle; read data is taken in the cycle after the strobe.
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd,
                       output logic [7:0] d);
        @(posedge clk_sys_in);
        bus_req_in <= '{addr: a, wdata: wd, wr: w, rd: !w};
        @(posedge clk_sys_in);
        bus_req_in <= '0;
        #1 d = bus_rdata_out;
    endtask
    // Length in cycles of the next internal reset, sampled mid-cycle.
    task automatic internal_reset_len(output int n);
        n = 0;
        @(negedge clk_sys_in);
        for (int i = 0; i < 4 && internal_reset_out !== 1'b1; i++)
            @(negedge clk_sys_in);
        while (internal_reset_out === 1'b1 && n < 5000)
        begin
            n++;
            @(negedge clk_sys_in);
        end
    endtask
    // Expected {valid, selector} after one instruction end.
    function automatic logic [5:0] exp_vec(logic [15:0] r, logic [15:0] en, logic m, logic s);
        if (s)
            return {1'b1, SIU_VEC_SWI};
        for (int i = 0; i < 16; i++)
            if (r[i] && en[i] && !m)
                return {1'b1, SIU_VEC_HW0 + 5'(i)};
        return 6'h00;
    endfunction
    // Cuts a hung run short.
    initial
    begin
        #500us;
        n_errors++;
        results();
    end
    // Main sequence.
    initial
    begin
        logic [7:0]  d;
        logic [15:0] r, en;
        logic [5:0]  e;
        int          n;
        int unsigned bits[7] = '{SIU_CAUSE_WDOG, SIU_CAUSE_ILLEGAL_OPCODE_CAUSE, SIU_CAUSE_ILLEGAL_OPCODE_CAUSE, SIU_CAUSE_ILLEGAL_ADDRESS_CAUSE,
                                 SIU_CAUSE_MON, SIU_CAUSE_LVI, SIU_CAUSE_PIN};
        void'($urandom(46702));
        repeat (3) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        internal_reset_len(n);
        check(16'(n), 16'h1043);
        bus(1'b0, SIU_ADDR_CAUSE, 8'h00, d);
        check(16'(d), 16'h0080);
        bus(1'b0, SIU_ADDR_CAUSE, 8'h00, d);
        check(16'(d), 16'h0000);
        bus(1'b1, SIU_ADDR_CFG, 8'h03, d);
        bus(1'b0, SIU_ADDR_CFG, 8'h00, d);
        check(16'(d), 16'h0003);
        bus(1'b0, 16'hFE02, 8'h00, d);
        check(16'(d), 16'h0000);
        // Stop with stop enabled, then a short recovery after a software wake.
        @(posedge clk_sys_in);
        cpu_in.stop_exec <= 1'b1;
        @(posedge clk_sys_in);
        cpu_in <= '{software_interrupt: 1'b1, default: 1'b0};
        #1 check(16'({clk_gen_en_out, cpu_clk_en_out, cnt_out}), 16'h0000);
        @(posedge clk_sys_in);
        cpu_in <= '0;
        repeat (31) @(posedge clk_sys_in);
        #1 check(16'(cpu_clk_en_out), 16'h0000);
        @(posedge clk_sys_in);
        #1 check(16'(cpu_clk_en_out), 16'h0001);
        // Stop must be disabled again so that it counts as an illegal opcode below.
        bus(1'b1, SIU_ADDR_CFG, 8'h00, d);
        for (int s = 0; s < 7; s++)
        begin
            @(posedge clk_sys_in);
            case (s)
                0: wdog_ovf_in <= 1'b1;
                1: cpu_in.illegal_op <= 1'b1;
                2: cpu_in.stop_exec <= 1'b1;
                3: cpu_in <= '{opcode_fetch: 1'b1, unmapped: 1'b1, default: 1'b0};
                4: mon_reset_in <= 1'b1;
                5: lvi_in <= 1'b1;
                default: ext_low <= 1'b1;
            endcase
            repeat (s == 6 ? 70 : 1) @(posedge clk_sys_in);
            {wdog_ovf_in, mon_reset_in, lvi_in, ext_low} <= 4'h0;
            cpu_in <= '0;
            internal_reset_len(n);
            if (s < 6)
                check(16'(n), s == 5 ? 16'h1043 : 16'h0043);
            bus(1'b0, SIU_ADDR_CAUSE, 8'h00, d);
            check(16'(d), 16'(8'h01 << bits[s]));
        end
        @(posedge clk_sys_in);
        cpu_in <= '{unmapped: 1'b1, default: 1'b0};
        @(posedge clk_sys_in);
        cpu_in <= '0;
        repeat (3) @(posedge clk_sys_in);
        #1 check(16'(internal_reset_out), 16'h0000);
        for (int k = 0; k < 16; k++)
        begin
            r = 16'($urandom);
            en = (k == 3) ? 16'h8000 : 16'($urandom);
            @(posedge clk_sys_in);
            irq_req_in <= r;
            irq_en_in <= en;
            cpu_in <= '{instr_end: 1'b1, i_mask: k[0], software_interrupt: k[2] & k[1], default: 1'b0};
            @(posedge clk_sys_in);
            cpu_in <= '0;
            bus(1'b0, SIU_ADDR_INT1, 8'h00, d);
            check(16'(d), 16'({r[5:0], 2'b00}));
            repeat (4) @(posedge clk_sys_in);
            e = exp_vec(r, en, k[0], k[2] & k[1]);
            #1 check(16'(stack_out.vec_valid), 16'(e[5]));
            // The selector only carries meaning while it is marked valid.
            if (e[5])
                check(16'(stack_out.vec), 16'(e[4:0]));
            @(posedge clk_sys_in);
            irq_req_in <= '0;
            cpu_in <= '{instr_end: 1'b1, return_from_interrupt: 1'b1, default: 1'b0};
            @(posedge clk_sys_in);
            cpu_in <= '0;
            repeat (6) @(posedge clk_sys_in);
            #1 check(16'(stack_out.vec_valid), 16'h0000);
        end
        results();
    end
endmodule

// >>> test/siu_pin_model.sv
// Reset pin net: pull-up, the unit's low drive and an outside low driver.
// Assumes the unit only ever drives the pin low.
module siu_pin_model (
    input  wire logic oe_in,  // Unit drives the pin low.
    input  wire logic low_in, // Outside circuit holds the pin low.
    output logic      pin_out // Resolved pin level.
);
    // The pull-up wins unless some party pulls the pin low.
    assign pin_out = !(oe_in || low_in);
endmodule

// >>> test/siu_props.sv
// Checker for siu_core: pin drive, reset phase lengths and stacking.
// Assumes the crystal clock is the only clock and the pin has a pull-up.
module siu_props
    import siu_pkg::*;
(
    input wire logic       clk_sys_in,         // Crystal clock.
    input wire logic       rstn_in,            // Reset, active low.
    input wire siu_cpu_t   cpu_in,             // CPU status.
    input wire logic       rst_pin_out,        // Pin drive value.
    input wire logic       rst_pin_oe_out,     // Pin drive enable.
    input wire siu_stack_t stack_out,          // Stacking control.
    input wire logic       internal_reset_out, // Internal reset.
    input wire logic       cpu_clk_en_out      // CPU clock enable.
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    logic [12:0] oe_cnt_reg;
    // Counts the cycles of the present low drive on the pin.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
        if (!rstn_in)
            oe_cnt_reg <= 13'h0000;
        else
            oe_cnt_reg <= rst_pin_oe_out ? oe_cnt_reg + 13'h0001 : 13'h0000;
    property p_pin_low; rst_pin_out == 1'b0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin high");
    property p_oe_len; $fell(rst_pin_oe_out) |-> oe_cnt_reg inside {13'h0020, 13'h1020}; endproperty
    a_oe_len: assert property (p_oe_len) else $error("pin low span");
    property p_tail; $fell(rst_pin_oe_out) |-> ##34 internal_reset_out ##1 !internal_reset_out; endproperty
    a_tail: assert property (p_tail) else $error("reset tail");
    property p_clk_off; rst_pin_oe_out && oe_cnt_reg > 13'h0028 && oe_cnt_reg < 13'h1000
        |-> !cpu_clk_en_out; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clocks early");
    property p_push; $rose(stack_out.push) |-> (stack_out.push && !stack_out.set_mask) [*4]
        ##1 (stack_out.push && stack_out.set_mask && stack_out.vec_valid) ##1 !stack_out.push; endproperty
    a_push: assert property (p_push) else $error("push train");
    property p_pc; $rose(stack_out.push) |-> stack_out.pc_minus_one == (stack_out.vec != SIU_VEC_SWI); endproperty
    a_pc: assert property (p_pc) else $error("pc kind");
    property p_end; $rose(stack_out.push) |-> $past(cpu_in.instr_end, 2); endproperty
    a_end: assert property (p_end) else $error("entry mid instruction");
    property p_hold; stack_out.vec_valid && $past(stack_out.vec_valid) |-> $stable(stack_out.vec); endproperty
    a_hold: assert property (p_hold) else $error("preempted");
    c_push: cover property ($rose(stack_out.push));
    c_oe: cover property ($fell(rst_pin_oe_out));
    c_internal_reset: cover property ($fell(internal_reset_out));
endmodule
bind siu_core siu_props i_props (.*);
